// [pst_defines.vh]
// Constants for the power-up self-test sequencer
`ifndef PST_DEFINES_VH
`define PST_DEFINES_VH
`define PST_NUM_W 6
`define PST_NUM_TESTS 12
`define PST_TEST_FIRST 6'o01
`define PST_TEST_MODEM 6'o05
`define PST_TEST_LAST_HARD 6'o11
`define PST_TEST_SOFT_FIRST 6'o12
`define PST_TEST_MEM 6'o13
`define PST_TEST_LAST 6'o14
`define PST_NUM_ZERO 6'o00
`define PST_NUM_ONE 6'o01
`define PST_ADDR_W 6
`define PST_ADDR_UNPLUGGED 6'o77
`define PST_CLK_KHZ 100000
`define PST_FLASH_MS 10000
`define PST_BLINK_MS 250
`define PST_FLASH_CYCLES (`PST_FLASH_MS * `PST_CLK_KHZ)
`define PST_BLINK_CYCLES (`PST_BLINK_MS * `PST_CLK_KHZ)
`define PST_CNT_W 32
`define PST_CNT_ZERO 32'h0
`define PST_CNT_ONE 32'h1
`endif

// [pst_sequencer.v]
// Power-up self-test sequencer: dispatches numbered tests and reports results
// Notes on behaviour
// - Start at power-up and on host command
// - LEDs show number of running test
// - Hardcore failure loops forever in failing test
// - Softcore error flashes number, reports to host
// - Test 13 memory test runs long
// - Test 1 checks I/O registers, instructions
// - Test 2 checks each ROM by CRC
// - Test 3 checks local RAM data, addressing
// - Test 4 uses serial chip internal loopback
// - Tests 6, 7 check interrupts, shared registers
// - Test 10 checks DMA timeout behaviour
// - Tests 11, 12 check cross-processor interrupts
`include "pst_defines.vh"
module pst_sequencer #(
  parameter [31:0] FLASH_CYCLES = `PST_FLASH_CYCLES,
  parameter [31:0] BLINK_CYCLES = `PST_BLINK_CYCLES
)(
  input wire clk,
  input wire rst_b,
  input wire host_start,
  input wire [`PST_ADDR_W-1:0] station_addr,
  input wire test_done,
  input wire test_fail,
  output reg [`PST_NUM_W-1:0] led_r,
  output reg test_go_r,
  output reg [`PST_NUM_TESTS-1:0] test_sel_r,
  output reg [`PST_NUM_W-1:0] test_num_r,
  output reg scc_loopback_r,
  output reg modem_loop_r,
  output reg busy_r,
  output reg seq_done_r,
  output reg hard_fail_r,
  output reg host_err_valid_r,
  output reg [`PST_NUM_W-1:0] host_err_num_r
);

  localparam [4:0] ST_IDLE = 5'b00001;
  localparam [4:0] ST_ISSUE = 5'b00010;
  localparam [4:0] ST_WAIT = 5'b00100;
  localparam [4:0] ST_FLASH = 5'b01000;
  localparam [4:0] ST_START = 5'b10000;

  reg [4:0] state_r;
  reg [4:0] state_nxt;
  reg [`PST_NUM_W-1:0] num_nxt;
  reg [`PST_CNT_W-1:0] flash_cnt_r;
  reg [`PST_CNT_W-1:0] flash_cnt_nxt;
  reg [`PST_CNT_W-1:0] blink_cnt_r;
  reg [`PST_CNT_W-1:0] blink_cnt_nxt;
  reg blink_on_r;
  reg blink_on_nxt;
  reg go_nxt;
  reg hard_nxt;
  reg done_nxt;
  reg err_valid_nxt;
  reg [`PST_NUM_W-1:0] err_num_nxt;

  wire is_last = (test_num_r == `PST_TEST_LAST);
  wire is_hard = (test_num_r <= `PST_TEST_LAST_HARD);
  wire unplugged = (station_addr == `PST_ADDR_UNPLUGGED);
  wire [`PST_NUM_W-1:0] num_inc = test_num_r + `PST_NUM_ONE;
  wire [`PST_NUM_W-1:0] sel_idx = test_num_r - `PST_NUM_ONE;
  wire skip_now = (state_r == ST_ISSUE) && (test_num_r == `PST_TEST_MODEM) && !unplugged;

  always @*
  begin
    state_nxt = state_r;
    num_nxt = test_num_r;
    flash_cnt_nxt = flash_cnt_r;
    blink_cnt_nxt = blink_cnt_r;
    blink_on_nxt = blink_on_r;
    go_nxt = 1'b0;
    hard_nxt = hard_fail_r;
    done_nxt = seq_done_r;
    err_valid_nxt = 1'b0;
    err_num_nxt = host_err_num_r;
    case (state_r)
      ST_START:
      begin
        // First state out of reset, so the run needs no command
        num_nxt = `PST_TEST_FIRST;
        hard_nxt = 1'b0;
        done_nxt = 1'b0;
        state_nxt = ST_ISSUE;
      end
      ST_IDLE:
      begin
        if (host_start)
        begin
          state_nxt = ST_START;
        end
      end
      ST_ISSUE:
      begin
        if (test_num_r == `PST_TEST_MODEM && !unplugged)
        begin
          num_nxt = num_inc;
        end
        else
        begin
          go_nxt = 1'b1;
          state_nxt = ST_WAIT;
        end
      end
      ST_WAIT:
      begin
        // Test engines own the test time, including the long memory run
        if (test_done && test_fail && is_hard)
        begin
          // Re-run the same test; the number moves on only if a re-run passes
          hard_nxt = 1'b1;
          state_nxt = ST_ISSUE;
        end
        else if (test_done && test_fail)
        begin
          err_valid_nxt = 1'b1;
          err_num_nxt = test_num_r;
          flash_cnt_nxt = `PST_CNT_ZERO;
          blink_cnt_nxt = `PST_CNT_ZERO;
          blink_on_nxt = 1'b1;
          state_nxt = ST_FLASH;
        end
        else if (test_done && is_last)
        begin
          done_nxt = 1'b1;
          state_nxt = ST_IDLE;
        end
        else if (test_done)
        begin
          num_nxt = num_inc;
          state_nxt = ST_ISSUE;
        end
      end
      ST_FLASH:
      begin
        flash_cnt_nxt = flash_cnt_r + `PST_CNT_ONE;
        if (blink_cnt_r >= BLINK_CYCLES - `PST_CNT_ONE)
        begin
          blink_cnt_nxt = `PST_CNT_ZERO;
          blink_on_nxt = !blink_on_r;
        end
        else
        begin
          blink_cnt_nxt = blink_cnt_r + `PST_CNT_ONE;
        end
        // Softcore errors never stop the run
        if (flash_cnt_r >= FLASH_CYCLES - `PST_CNT_ONE)
        begin
          if (is_last)
          begin
            done_nxt = 1'b1;
            state_nxt = ST_IDLE;
          end
          else
          begin
            num_nxt = num_inc;
            state_nxt = ST_ISSUE;
          end
        end
      end
      default:
      begin
        state_nxt = ST_START;
      end
    endcase
  end

  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_r <= ST_START;
      test_num_r <= `PST_NUM_ZERO;
      flash_cnt_r <= `PST_CNT_ZERO;
      blink_cnt_r <= `PST_CNT_ZERO;
      blink_on_r <= 1'b0;
      test_go_r <= 1'b0;
      hard_fail_r <= 1'b0;
      seq_done_r <= 1'b0;
      host_err_valid_r <= 1'b0;
      host_err_num_r <= `PST_NUM_ZERO;
    end
    else
    begin
      state_r <= state_nxt;
      test_num_r <= num_nxt;
      flash_cnt_r <= flash_cnt_nxt;
      blink_cnt_r <= blink_cnt_nxt;
      blink_on_r <= blink_on_nxt;
      test_go_r <= go_nxt;
      hard_fail_r <= hard_nxt;
      seq_done_r <= done_nxt;
      host_err_valid_r <= err_valid_nxt;
      host_err_num_r <= err_num_nxt;
    end
  end

  // Engine select and test-specific modes, registered from the current number
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      test_sel_r <= {`PST_NUM_TESTS{1'b0}};
      scc_loopback_r <= 1'b0;
      modem_loop_r <= 1'b0;
      busy_r <= 1'b0;
      led_r <= `PST_NUM_ZERO;
    end
    else
    begin
      busy_r <= (state_nxt != ST_IDLE);
      if (skip_now)
      begin
        // Skipped test never shows its number or selects its engine
        modem_loop_r <= 1'b0;
      end
      else if (state_nxt == ST_ISSUE || state_nxt == ST_WAIT)
      begin
        // One engine per bit: I/O+CPU, ROM CRC, RAM, serial, modem,
        // interrupts, shared regs, DMA timeout, host irq, boot, memory, CPU
        test_sel_r <= {{(`PST_NUM_TESTS-1){1'b0}}, 1'b1} << sel_idx;
        scc_loopback_r <= (test_num_r == `PST_TEST_MODEM - `PST_NUM_ONE);
        modem_loop_r <= (test_num_r == `PST_TEST_MODEM) && unplugged;
        led_r <= test_num_r;
      end
      else if (state_nxt == ST_FLASH)
      begin
        test_sel_r <= {`PST_NUM_TESTS{1'b0}};
        scc_loopback_r <= 1'b0;
        modem_loop_r <= 1'b0;
        led_r <= blink_on_nxt ? test_num_r : `PST_NUM_ZERO;
      end
      else
      begin
        test_sel_r <= {`PST_NUM_TESTS{1'b0}};
        scc_loopback_r <= 1'b0;
        modem_loop_r <= 1'b0;
        led_r <= `PST_NUM_ZERO;
      end
    end
  end

endmodule

// [pst_engine_model.sv]
// Behavioural test engines answering the sequencer
module pst_engine_model (
  input wire clk,
  input wire test_go_r,
  input wire [11:0] test_sel_r,
  input wire [11:0] fail_mask,
  output logic test_done = 1'b0,
  output logic test_fail = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_r = 4'h0;
  // Test one is slow; fail line scrambles between results
  always @(posedge clk)
  begin
    cnt_r <= test_go_r ? {test_sel_r[0], 3'h1} : cnt_r - 4'(cnt_r != 4'h0);
    test_done <= cnt_r == 4'h1;
    test_fail <= cnt_r == 4'h1 ? |(test_sel_r & fail_mask) : ~test_fail;
  end
endmodule

// [pst_seq_asserts.sv]
// Port checks for the self-test sequencer
module pst_seq_asserts (
  input wire clk,
  input wire rst_b,
  input wire [5:0] station_addr,
  input wire [5:0] led_r,
  input wire test_go_r,
  input wire [11:0] test_sel_r,
  input wire [5:0] test_num_r,
  input wire scc_loopback_r,
  input wire modem_loop_r,
  input wire busy_r,
  input wire seq_done_r,
  input wire hard_fail_r,
  input wire host_err_valid_r,
  input wire [5:0] host_err_num_r
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  AST_START: assert property ($rose(busy_r) |-> ##[1:2] test_go_r && test_num_r == 6'h01)
    else $error("bad start");
  AST_CLEAR: assert property ($rose(busy_r) |=> !seq_done_r)
    else $error("done not cleared");
  AST_LED: assert property (test_go_r |-> led_r == test_num_r) else $error("bad led");
  AST_SEL: assert property (test_go_r |-> test_sel_r == (12'h001 << (test_num_r - 6'h01)))
    else $error("bad select");
  AST_MODEM: assert property (test_go_r && test_num_r == 6'h05 |-> $past(station_addr) == 6'h3f)
    else $error("bad modem");
  AST_SKIP: assert property (led_r == 6'h05 |-> modem_loop_r && test_sel_r[4])
    else $error("skipped test shown");
  AST_LOOP: assert property (test_go_r && test_num_r == 6'h04 |-> scc_loopback_r)
    else $error("no loop");
  AST_HARD: assert property ($rose(hard_fail_r) |-> test_num_r <= 6'h09 ##[1:3] test_go_r)
    else $error("bad hard");
  AST_HALT: assert property (hard_fail_r |=> $stable(test_num_r)) else $error("moved");
  AST_SOFT: assert property (host_err_valid_r |-> host_err_num_r inside {[6'h0a:6'h0c]})
    else $error("bad soft");
  AST_FLASH: assert property (host_err_valid_r |-> led_r == host_err_num_r)
    else $error("flash not lit");
  AST_UP: assert property ($changed(test_num_r) && test_num_r > 6'h01 |->
    (test_num_r - $past(test_num_r) == 6'h01 || test_num_r == 6'h06))
    else $error("bad order");
endmodule
bind pst_sequencer pst_seq_asserts u_chk (.*);

// [tb_top.sv]
// Bench for the self-test sequencer
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst_b = 1'b0, host_start = 1'b0;
  logic [5:0] station_addr = 6'h00, led_r, test_num_r, host_err_num_r;
  logic [11:0] fail_mask = 12'h000, test_sel_r;
  logic test_done, test_fail, test_go_r, scc_loopback_r, modem_loop_r, busy_r;
  logic seq_done_r, hard_fail_r, host_err_valid_r;
  logic [5:0] q[$];
  int num_errors = 0, compares = 0;
  int cyc = 0, err_cyc = 0, gap = 0;
  initial forever #5 clk = ~clk;
  pst_sequencer #(.FLASH_CYCLES(32'd20), .BLINK_CYCLES(32'd4)) u_dut (
    .clk(clk),
    .rst_b(rst_b),
    .host_start(host_start),
    .station_addr(station_addr),
    .test_done(test_done),
    .test_fail(test_fail),
    .led_r(led_r),
    .test_go_r(test_go_r),
    .test_sel_r(test_sel_r),
    .test_num_r(test_num_r),
    .scc_loopback_r(scc_loopback_r),
    .modem_loop_r(modem_loop_r),
    .busy_r(busy_r),
    .seq_done_r(seq_done_r),
    .hard_fail_r(hard_fail_r),
    .host_err_valid_r(host_err_valid_r),
    .host_err_num_r(host_err_num_r)
  );
  pst_engine_model u_eng (
    .clk(clk),
    .test_go_r(test_go_r),
    .test_sel_r(test_sel_r),
    .fail_mask(fail_mask),
    .test_done(test_done),
    .test_fail(test_fail)
  );
  // Sampled away from the launching edge; gap runs from error report to next issue
  always @(negedge clk)
  begin
    cyc <= cyc + 1;
    if (host_err_valid_r === 1'b1)
      err_cyc <= cyc;
    if (test_go_r === 1'b1)
    begin
      q.push_back(test_num_r);
      gap <= cyc - err_cyc;
    end
  end
  task automatic chk(input logic [11:0] got, exp);
    compares++;
    num_errors += (got !== exp);
    if (got !== exp)
      $display("[FAIL] %0t got=%h exp=%h", $time, got, exp);
  endtask
  task automatic end_sim();
    $display("errors=%0d compares=%0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Host start skips reset so the idle path is exercised
  task automatic run(input logic [5:0] addr, input logic [11:0] mask, input bit host);
    int i;
    q.delete();
    station_addr = addr;
    fail_mask = mask;
    host_start = host;
    rst_b = host;
    repeat (5) @(negedge clk);
    rst_b = 1'b1;
    host_start = 1'b0;
    for (i = 0; i < 3000 && (mask[2] ? hard_fail_r : seq_done_r) !== 1'b1; i++)
      @(negedge clk);
    num_errors += (i == 3000);
    if (i == 3000)
      end_sim();
  endtask
  task automatic sc_powerup();
    run(6'h00, 12'h000, 1'b0);
    chk(12'(q.size()), 12'h00b);
    chk(12'(q[4]), 12'h006);
    chk(12'({busy_r, led_r}), 12'h000);
  endtask
  // Flash of 20 cycles plus the issue cycle before the next test
  task automatic sc_host_soft();
    run(6'h3f, 12'h400, 1'b1);
    chk(12'(q[4]), 12'h005);
    chk(12'(q.size()), 12'h00c);
    chk(12'(host_err_num_r), 12'h00b);
    chk(12'(gap), 12'h015);
  endtask
  task automatic sc_hard();
    run(6'h00, 12'h004, 1'b0);
    repeat (40) @(negedge clk);
    chk(12'(led_r), 12'h003);
    chk(12'(q.size() > 6), 12'h001);
    chk(12'(seq_done_r), 12'h000);
  endtask
  initial
  begin
    sc_powerup();
    sc_host_soft();
    sc_hard();
    end_sim();
  end
endmodule
